// ### pkg/ladder_pkg.sv
package ladder_pkg;

    localparam int          ADDR_W      = 10;
    localparam int          BIT_ADDR_W  = 12;
    localparam int          INSTR_W     = 4 + BIT_ADDR_W;
    localparam int          STACK_DEPTH = 8;
    localparam int          STACK_PTR_W = 4;

    localparam logic [ADDR_W-1:0] PROG_START = 10'h000;

    typedef enum logic [3:0] {
        OP_NOP          = 4'h0,
        OP_LOAD         = 4'h1,
        OP_LOAD_INV     = 4'h2,
        OP_SERIES       = 4'h3,
        OP_SERIES_INV   = 4'h4,
        OP_PARALLEL     = 4'h5,
        OP_PARALLEL_INV = 4'h6,
        OP_OUT          = 4'h7,
        OP_OUT_INV      = 4'h8,
        OP_BLOCK_AND    = 4'h9,
        OP_BLOCK_OR     = 4'ha,
        OP_END          = 4'hf
    } opcode_e;

    typedef enum logic [2:0] {
        ST_SEARCH = 3'b000,
        ST_SCAN   = 3'b001,
        ST_FETCH  = 3'b011,
        ST_READ   = 3'b010,
        ST_EXEC   = 3'b110,
        ST_HALT   = 3'b100
    } state_e;

endpackage

// ### rtl/condition_stack.sv
`timescale 1ns/1ps
module condition_stack
    import ladder_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       clear,
    input  wire logic       push,
    input  wire logic       pop,
    input  wire logic       push_value,
    output logic            top_value,
    output logic            overflow
);

    logic [DEPTH-1:0]       slot_reg;
    logic [DEPTH-1:0]       slot_next;
    logic [STACK_PTR_W-1:0] count_reg;
    logic [STACK_PTR_W-1:0] count_next;
    logic                   ovf_reg;
    logic                   ovf_next;

    // Slots shift like a bit stack, so the most recent save is always slot zero.
    always_comb begin
        slot_next  = slot_reg;
        count_next = count_reg;
        ovf_next   = ovf_reg;
        if (clear) begin
            count_next = '0;
            ovf_next   = 1'b0;
        end else if (push) begin
            slot_next = {slot_reg[DEPTH-2:0], push_value};
            if (count_reg == STACK_PTR_W'(DEPTH)) begin
                ovf_next = 1'b1;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end else if (pop) begin
            slot_next = {1'b0, slot_reg[DEPTH-1:1]};
            if (count_reg != '0) begin
                count_next = count_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slot_reg  <= '0;
            count_reg <= '0;
            ovf_reg   <= 1'b0;
        end else begin
            slot_reg  <= slot_next;
            count_reg <= count_next;
            ovf_reg   <= ovf_next;
        end
    end

    assign top_value = slot_reg[0];
    assign overflow  = ovf_reg;

endmodule

// ### rtl/ladder_logic_evaluator.sv
`timescale 1ns/1ps
// Operation
// - Parallel ORs condition with operand bit; inverted form uses the complement.
// - Mixed series and parallel instructions apply one by one in program order.
// - Output drives its bit equal to the execution condition.
// - Inverted output drives its bit to the complement of the condition.
// - Each scan runs from start to first end, then restarts at start.
// - Nothing after the first end instruction executes.
// - A program without any end instruction never executes.
// - End takes no operand and no condition on its line.
// - A mid-line load saves the condition and restarts from its operand.
// - Only a mid-line load creates a saved condition; each combine takes the latest one still saved.
// - Block conjunction ANDs the condition with the latest saved condition.
// - Block disjunction ORs the condition with the latest saved condition.
// - Block combine instructions carry no operand.
// - Every condition instruction occupies exactly one program line.
// - Series ANDs condition with operand bit; inverted form uses the complement.
// - Load starts the condition at the operand bit or its complement.
// - The saved-condition buffer holds at least eight pending blocks.
// - Execution starts at address zero; each address holds one instruction.
module ladder_logic_evaluator
    import ladder_pkg::*;
#(
    parameter int PROG_DEPTH = 1 << ADDR_W
) (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    output logic [ADDR_W-1:0]          prog_addr,
    input  wire logic [INSTR_W-1:0]    prog_data,
    output logic [BIT_ADDR_W-1:0]      bit_addr,
    input  wire logic                  bit_rdata,
    output logic                       bit_we,
    output logic                       bit_wdata,
    output logic                       running,
    output logic                       no_end_fault,
    output logic                       scan_done,
    output logic                       buffer_overflow
);

    state_e                  state_reg, state_next;
    logic [ADDR_W-1:0]       pc_reg, pc_next;
    opcode_e                 op_reg, op_next;
    logic [BIT_ADDR_W-1:0]   operand_reg, operand_next;
    logic                    cond_reg, cond_next;
    logic                    line_open_reg, line_open_next;
    logic                    we_reg, we_next;
    logic                    wdata_reg, wdata_next;
    logic                    done_reg, done_next;
    logic                    fault_reg, fault_next;
    logic                    tail_reg, tail_next;
    logic                    push, pop, clear, saved_cond, ovf;
    logic                    opnd;
    logic                    last_addr;

    // Program memory answers one cycle after prog_addr; the bit area answers bit_addr in the same cycle.
    condition_stack #(.DEPTH(STACK_DEPTH)) u_stack (
        .clk        (clk),
        .rst_b      (rst_b),
        .clear      (clear),
        .push       (push),
        .pop        (pop),
        .push_value (cond_reg),
        .top_value  (saved_cond),
        .overflow   (ovf)
    );

    assign last_addr = (pc_reg == ADDR_W'(PROG_DEPTH - 1));
    assign opnd      = bit_rdata;

    always_comb begin
        state_next     = state_reg;
        pc_next        = pc_reg;
        op_next        = op_reg;
        operand_next   = operand_reg;
        cond_next      = cond_reg;
        line_open_next = line_open_reg;
        we_next        = 1'b0;
        wdata_next     = wdata_reg;
        done_next      = 1'b0;
        fault_next     = fault_reg;
        tail_next      = 1'b0;
        push           = 1'b0;
        pop            = 1'b0;
        clear          = 1'b0;
        case (state_reg)
            // A program is only run after an end instruction has been found, which costs a search
            // of memory up to that end at start-up but keeps a program without one inert.
            // The word on prog_data belongs to the address one below pc_reg, except in the
            // first cycle after reset, so the last address is judged one cycle late.
            ST_SEARCH: begin
                pc_next   = pc_reg + 1'b1;
                tail_next = last_addr;
                if (opcode_e'(prog_data[INSTR_W-1 -: 4]) == OP_END) begin
                    if (pc_reg == '0 && !tail_reg) begin
                        state_next = ST_HALT;
                    end else begin
                        state_next = ST_SCAN;
                        pc_next    = PROG_START;
                    end
                end else if (tail_reg) begin
                    state_next = ST_HALT;
                end
            end
            ST_SCAN: begin
                // Idle cycle that lets the word at the start address arrive before the fetch.
                state_next = ST_FETCH;
            end
            ST_FETCH: begin
                op_next      = opcode_e'(prog_data[INSTR_W-1 -: 4]);
                operand_next = prog_data[BIT_ADDR_W-1:0];
                state_next   = ST_READ;
            end
            ST_READ: begin
                // Advancing here gives the memory its cycle before the next fetch.
                state_next = ST_EXEC;
                pc_next    = pc_reg + 1'b1;
            end
            ST_EXEC: begin
                state_next = ST_FETCH;
                case (op_reg)
                    OP_LOAD, OP_LOAD_INV: begin
                        if (line_open_reg) begin
                            push = 1'b1;
                        end
                        cond_next      = (op_reg == OP_LOAD_INV) ? ~opnd : opnd;
                        line_open_next = 1'b1;
                    end
                    OP_SERIES:       cond_next = cond_reg & opnd;
                    OP_SERIES_INV:   cond_next = cond_reg & ~opnd;
                    OP_PARALLEL:     cond_next = cond_reg | opnd;
                    OP_PARALLEL_INV: cond_next = cond_reg | ~opnd;
                    OP_BLOCK_AND: begin
                        cond_next = cond_reg & saved_cond;
                        pop       = 1'b1;
                    end
                    OP_BLOCK_OR: begin
                        cond_next = cond_reg | saved_cond;
                        pop       = 1'b1;
                    end
                    OP_OUT, OP_OUT_INV: begin
                        we_next        = 1'b1;
                        wdata_next     = (op_reg == OP_OUT_INV) ? ~cond_reg : cond_reg;
                        line_open_next = 1'b0;
                        clear          = 1'b1;
                    end
                    OP_END: begin
                        // The operand field is ignored and the line is closed.
                        pc_next        = PROG_START;
                        line_open_next = 1'b0;
                        clear          = 1'b1;
                        done_next      = 1'b1;
                        state_next     = ST_SCAN;
                    end
                    default: ;
                endcase
            end
            ST_HALT: begin
                fault_next = 1'b1;
            end
            default: state_next = ST_SEARCH;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg     <= ST_SEARCH;
            pc_reg        <= PROG_START;
            op_reg        <= OP_NOP;
            operand_reg   <= '0;
            cond_reg      <= 1'b0;
            line_open_reg <= 1'b0;
            we_reg        <= 1'b0;
            wdata_reg     <= 1'b0;
            done_reg      <= 1'b0;
            fault_reg     <= 1'b0;
            tail_reg      <= 1'b0;
        end else begin
            state_reg     <= state_next;
            pc_reg        <= pc_next;
            op_reg        <= op_next;
            operand_reg   <= operand_next;
            cond_reg      <= cond_next;
            line_open_reg <= line_open_next;
            we_reg        <= we_next;
            wdata_reg     <= wdata_next;
            done_reg      <= done_next;
            fault_reg     <= fault_next;
            tail_reg      <= tail_next;
        end
    end

    // Output register of the bit address mirrors the latched operand.
    logic [BIT_ADDR_W-1:0] baddr_reg;
    logic                  run_reg;
    logic                  ovf_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            baddr_reg <= '0;
            run_reg   <= 1'b0;
            ovf_reg   <= 1'b0;
        end else begin
            baddr_reg <= operand_next;
            run_reg   <= (state_next != ST_SEARCH) && (state_next != ST_HALT);
            ovf_reg   <= ovf;
        end
    end

    assign prog_addr       = pc_reg;
    assign bit_addr        = baddr_reg;
    assign bit_we          = we_reg;
    assign bit_wdata       = wdata_reg;
    assign running         = run_reg;
    assign no_end_fault    = fault_reg;
    assign scan_done       = done_reg;
    assign buffer_overflow = ovf_reg;

    out_follows_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_EXEC && op_reg == OP_OUT) |=> (bit_we && bit_wdata == $past(cond_reg)))
        else $error("output bit does not follow condition");
    out_inv_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_EXEC && op_reg == OP_OUT_INV) |=> (bit_we && bit_wdata != $past(cond_reg)))
        else $error("inverted output not complemented");
    par_or_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_EXEC && op_reg == OP_PARALLEL) |=> cond_reg == ($past(cond_reg) | $past(opnd)))
        else $error("parallel condition wrong");
    ser_and_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_EXEC && op_reg == OP_SERIES_INV) |=> cond_reg == ($past(cond_reg) & ~$past(opnd)))
        else $error("inverted series condition wrong");
    load_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_EXEC && op_reg == OP_LOAD_INV) |=> cond_reg == ~$past(opnd))
        else $error("inverted load start wrong");
    end_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_EXEC && op_reg == OP_END) |=> (prog_addr == PROG_START && scan_done))
        else $error("end did not wrap scan");
    blk_and_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_EXEC && op_reg == OP_BLOCK_AND) |=> cond_reg == ($past(cond_reg) & $past(saved_cond)))
        else $error("block conjunction wrong");
    blk_or_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_EXEC && op_reg == OP_BLOCK_OR) |=> cond_reg == ($past(cond_reg) | $past(saved_cond)))
        else $error("block disjunction wrong");
    no_end_halt_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == ST_HALT) |-> (!bit_we && !running))
        else $error("program ran without end");
    scan_cov: cover property (@(posedge clk) disable iff (!rst_b) scan_done);
    push_cov: cover property (@(posedge clk) disable iff (!rst_b) push);
    fault_cov: cover property (@(posedge clk) disable iff (!rst_b) no_end_fault);

endmodule

// ### bench/program_store.sv
`timescale 1ns/1ps
module program_store
    import ladder_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic [ADDR_W-1:0]     prog_addr,
    output logic [INSTR_W-1:0]         prog_data,
    input  wire logic [BIT_ADDR_W-1:0] bit_addr,
    output logic                       bit_rdata,
    input  wire logic                  bit_we,
    input  wire logic                  bit_wdata
);
    // One whole instruction word per address, laid out from address zero.
    logic [INSTR_W-1:0] rom  [0:(1<<ADDR_W)-1];
    logic               bits [0:(1<<BIT_ADDR_W)-1];

    // Synchronous read, so a fetch that samples too early sees the old word.
    always_ff @(posedge clk) begin
        prog_data <= rom[prog_addr];
    end

    assign bit_rdata = bits[bit_addr];

    always @(posedge clk) begin
        if (bit_we) begin
            bits[bit_addr] <= bit_wdata;
        end
    end
endmodule

// ### bench/ladder_logic_evaluator_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module ladder_logic_evaluator_bench
    import ladder_pkg::*;
;
    localparam int DEPTH = 64;
    logic                  clk;
    logic                  rst_b;
    logic [ADDR_W-1:0]     prog_addr;
    logic [INSTR_W-1:0]    prog_data;
    logic [BIT_ADDR_W-1:0] bit_addr;
    logic                  bit_rdata;
    logic                  bit_we;
    logic                  bit_wdata;
    logic                  running;
    logic                  no_end_fault;
    logic                  scan_done;
    logic                  buffer_overflow;
    logic [ADDR_W-1:0]     max_addr;
    logic                  ovf_seen;
    logic [INSTR_W-1:0]    prog [$];
    int                    err_total;
    int                    comparisons;

    // A short search depth keeps the end search after each reset brief.
    ladder_logic_evaluator #(.PROG_DEPTH(DEPTH)) uut (.clk(clk), .rst_b(rst_b),
        .prog_addr(prog_addr), .prog_data(prog_data), .bit_addr(bit_addr),
        .bit_rdata(bit_rdata), .bit_we(bit_we), .bit_wdata(bit_wdata),
        .running(running), .no_end_fault(no_end_fault), .scan_done(scan_done),
        .buffer_overflow(buffer_overflow));
    program_store mem (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
        .bit_addr(bit_addr), .bit_rdata(bit_rdata), .bit_we(bit_we), .bit_wdata(bit_wdata));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [INSTR_W-1:0] ins(opcode_e op, int a);
        return {op, a[BIT_ADDR_W-1:0]};
    endfunction

    task complete_run;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // The program only changes while the block is held in reset.
    task load_reset;
        @(negedge clk);
        rst_b = 1'b0;
        ovf_seen = 1'b0;
        for (int i = 0; i < (1 << ADDR_W); i++) mem.rom[i] = ins(OP_NOP, 0);
        for (int i = 0; i < (1 << BIT_ADDR_W); i++) mem.bits[i] = 1'b0;
        foreach (prog[i]) mem.rom[i] = prog[i];
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
    endtask

    task set_in(input logic [7:0] v);
        for (int k = 0; k < 8; k++) mem.bits[k] = v[k];
    endtask

    task wait_scans(input int n);
        int seen;
        seen = 0;
        for (int i = 0; i < 4000 && seen < n; i++) begin
            @(negedge clk);
            if (scan_done === 1'b1) seen++;
            if (prog_addr > max_addr) max_addr = prog_addr;
            if (buffer_overflow !== 1'b0) ovf_seen = 1'b1;
        end
        if (seen < n) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, seen, n);
            complete_run;
        end
    endtask

    task test_series_parallel;
        logic [4:0] b;
        logic       c;
        prog = '{ins(OP_LOAD, 0), ins(OP_SERIES, 1), ins(OP_PARALLEL, 2),
            ins(OP_SERIES_INV, 3), ins(OP_PARALLEL_INV, 4), ins(OP_OUT, 'h200),
            ins(OP_OUT_INV, 'h201), ins(OP_LOAD_INV, 0), ins(OP_PARALLEL_INV, 1),
            ins(OP_OUT, 'h202), ins(OP_END, 0)};
        load_reset;
        for (int v = 0; v < 32; v++) begin
            b = v[4:0];
            set_in({3'h0, b});
            wait_scans(2);
            c = (((b[0] & b[1]) | b[2]) & ~b[3]) | ~b[4];
            `CHK(mem.bits['h200], c)
            `CHK(mem.bits['h201], ~c)
            `CHK(mem.bits['h202], ~b[0] | ~b[1])
        end
        $display("test series_parallel done");
    endtask

    task test_blocks;
        logic [3:0] b;
        prog = '{ins(OP_LOAD, 0), ins(OP_PARALLEL, 1), ins(OP_LOAD, 2),
            ins(OP_PARALLEL_INV, 3), ins(OP_BLOCK_AND, 'hfff), ins(OP_OUT, 'h210),
            ins(OP_LOAD, 0), ins(OP_SERIES_INV, 1), ins(OP_LOAD_INV, 2),
            ins(OP_SERIES_INV, 3), ins(OP_BLOCK_OR, 'h0ff), ins(OP_OUT, 'h211),
            ins(OP_LOAD, 0), ins(OP_LOAD, 1), ins(OP_LOAD, 2), ins(OP_BLOCK_OR, 0),
            ins(OP_BLOCK_AND, 0), ins(OP_OUT, 'h212), ins(OP_END, 'hfff)};
        load_reset;
        for (int v = 0; v < 16; v++) begin
            b = v[3:0];
            set_in({4'h0, b});
            wait_scans(2);
            `CHK(mem.bits['h210], (b[0] | b[1]) & (b[2] | ~b[3]))
            `CHK(mem.bits['h211], (b[0] & ~b[1]) | (~b[2] & ~b[3]))
            `CHK(mem.bits['h212], b[0] & (b[1] | b[2]))
        end
        $display("test blocks done");
    endtask

    task test_eight_blocks;
        logic [7:0] v;
        prog.delete();
        for (int k = 0; k < 8; k++) prog.push_back(ins(OP_LOAD, k));
        for (int k = 0; k < 7; k++) prog.push_back(ins(OP_BLOCK_AND, 0));
        prog.push_back(ins(OP_OUT, 'h220));
        for (int k = 0; k < 8; k++) prog.push_back(ins(OP_LOAD, k));
        for (int k = 0; k < 7; k++) prog.push_back(ins(OP_BLOCK_OR, 0));
        prog.push_back(ins(OP_OUT, 'h221));
        prog.push_back(ins(OP_END, 0));
        load_reset;
        for (int k = 0; k < 10; k++) begin
            v = (k < 8) ? ~(8'h01 << k) : ((k == 8) ? 8'hff : 8'h00);
            set_in(v);
            wait_scans(2);
            `CHK(mem.bits['h220], &v)
            `CHK(mem.bits['h221], |v)
            `CHK(ovf_seen, 1'b0)
        end
        $display("test eight_blocks done");
    endtask

    task test_early_end;
        prog = '{ins(OP_LOAD, 0), ins(OP_OUT, 'h230), ins(OP_END, 0),
            ins(OP_OUT_INV, 'h231), ins(OP_OUT, 'h231), ins(OP_END, 0)};
        load_reset;
        set_in(8'h01);
        wait_scans(1);
        max_addr = '0;
        wait_scans(3);
        `CHK(mem.bits['h230], 1'b1)
        `CHK(mem.bits['h231], 1'b0)
        `CHK(max_addr < 4, 1'b1)
        `CHK(running, 1'b1)
        $display("test early_end done");
    endtask

    // A long fixed wait is the only way to see that nothing ever happens.
    // A program whose first word is an end word is empty and is treated like one without.
    task test_no_end;
        int done_seen;
        for (int p = 0; p < 2; p++) begin
            done_seen = 0;
            if (p == 0) begin
                prog = '{ins(OP_LOAD, 0), ins(OP_OUT, 'h240)};
            end else begin
                prog = '{ins(OP_END, 0), ins(OP_LOAD, 0), ins(OP_OUT, 'h240), ins(OP_END, 0)};
            end
            load_reset;
            set_in(8'h01);
            repeat (300) begin
                @(negedge clk);
                if (scan_done !== 1'b0 || bit_we !== 1'b0) done_seen++;
            end
            `CHK(no_end_fault, 1'b1)
            `CHK(running, 1'b0)
            `CHK(mem.bits['h240], 1'b0)
            `CHK(done_seen, 0)
        end
        $display("test no_end done");
    endtask

    initial begin
        rst_b = 1'b0;
        err_total = 0;
        comparisons = 0;
        max_addr = '0;
        test_series_parallel;
        test_blocks;
        test_eight_blocks;
        test_early_end;
        test_no_end;
        complete_run;
    end
endmodule
